//--- design/cet_pkg.sv
// Shared types and constants of the execution timing controller.
package cet_pkg;

	// ------------------------------------------------------------
	// Instruction classes seen at issue
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_ALU   = 4'h0,
		OP_MUL   = 4'h1,
		OP_MAC   = 4'h2,
		OP_NMAC  = 4'h3,
		OP_LOAD  = 4'h4,
		OP_STORE = 4'h5,
		OP_LWARX = 4'h6,
		OP_STWCX = 4'h7,
		OP_LMW   = 4'h8,
		OP_STMW  = 4'h9
	} cet_op_t;

	typedef enum logic [1:0] {
		MF_HH = 2'h0,
		MF_HW = 2'h1,
		MF_WW = 2'h2
	} cet_mform_t;

	typedef enum logic [1:0] {
		IF_SEQ         = 2'h0,
		IF_BR_DECODE   = 2'h1,
		IF_BR_PREFETCH = 2'h2
	} cet_ifkind_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_BUSY  = 2'b01,
		ST_WAIT  = 2'b11,
		ST_SPLIT = 2'b10
	} cet_state_t;

	// ------------------------------------------------------------
	// Timing figures in core clock cycles
	// ------------------------------------------------------------
	localparam logic [2:0] MAC_REISSUE    = 3'h1;
	localparam logic [2:0] MAC_LATENCY    = 3'h2;
	localparam logic [2:0] HH_REISSUE     = 3'h1;
	localparam logic [2:0] HH_LATENCY     = 3'h2;
	localparam logic [2:0] HW_REISSUE     = 3'h2;
	localparam logic [2:0] HW_LATENCY     = 3'h3;
	localparam logic [2:0] WW_REISSUE     = 3'h4;
	localparam logic [2:0] WW_LATENCY     = 3'h5;
	localparam logic [2:0] STWCX_CYCLES   = 3'h2;
	localparam logic [2:0] IMISS_SEQ      = 3'h3;
	localparam logic [2:0] IMISS_DECODE   = 3'h5;
	localparam logic [2:0] IMISS_PREFETCH = 3'h4;
	localparam int         MUL_SLOTS      = 4;

	// ------------------------------------------------------------
	// Access geometry and field positions
	// ------------------------------------------------------------
	localparam logic [2:0] WORD_BYTES    = 3'h4;
	localparam logic [1:0] WORD_ALIGN_LO = 2'h0;
	localparam logic [1:0] STORE_Q_DEPTH = 2'h3;
	localparam int         HALF_MSB      = 15;
	localparam int         SL_OV         = 32;
	localparam int         SL_OE         = 33;
	localparam int         SL_RC         = 34;

endpackage

//--- design/cet_mul_sizer.sv
// Multiplier class selection from instruction form and operand width.
`timescale 1ns/1ps

module cet_mul_sizer
	import cet_pkg::*;
(
	// Operation
	input  wire logic        is_mac,
	input  cet_mform_t       form,
	input  wire logic        is_unsigned,
	input  wire logic [31:0] opa,
	input  wire logic [31:0] opb,
	// Cycle figures
	output logic [2:0]       reissue,
	output logic [2:0]       latency
);

	// ------------------------------------------------------------
	// Operand narrowing
	// ------------------------------------------------------------
	// An operand is narrow when its upper bits only repeat the sign (or are zero for unsigned).
	wire a_half = is_unsigned ? (opa[31:HALF_MSB+1] == '0) : (opa[31:HALF_MSB] == {17{opa[HALF_MSB]}});
	wire b_half = is_unsigned ? (opb[31:HALF_MSB+1] == '0) : (opb[31:HALF_MSB] == {17{opb[HALF_MSB]}});
	wire hh_cls = is_mac || (form == MF_HH);
	wire hw_cls = (form == MF_HW) || (a_half || b_half);

	assign reissue = hh_cls ? HH_REISSUE : (hw_cls ? HW_REISSUE : WW_REISSUE);
	assign latency = hh_cls ? HH_LATENCY : (hw_cls ? HW_LATENCY : WW_LATENCY);

endmodule // cet_mul_sizer

//--- design/cet_access_splitter.sv
// Cuts an access into pieces that never cross a word boundary.
`timescale 1ns/1ps

module cet_access_splitter
	import cet_pkg::*;
(
	// Remaining access
	input  wire logic [1:0] addr_lo,
	input  wire logic [6:0] remain,
	// Piece taken this cycle
	output logic [2:0]      chunk,
	output logic            crosses
);

	wire [2:0] room = WORD_BYTES - {1'b0, addr_lo};

	assign crosses = remain > {4'h0, room};
	assign chunk   = crosses ? room : remain[2:0];

endmodule // cet_access_splitter

//--- design/cet_timing_ctrl.sv
// Execute-stage timing controller: multiplier pipe, loads, stores, strings, fetch misses.
`timescale 1ns/1ps

module cet_timing_ctrl
	import cet_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// Issue from the decode stage
	input  wire logic        iss_valid,
	output logic             iss_ready,
	input  cet_op_t          iss_op,
	input  cet_mform_t       iss_mform,
	input  wire logic        iss_unsigned,
	input  wire logic        iss_high,
	input  wire logic        iss_oe,
	input  wire logic        iss_rc,
	input  wire logic        iss_acc_fwd,
	input  wire logic        iss_next_mul,
	input  wire logic        iss_next_dep,
	input  wire logic [31:0] iss_opa,
	input  wire logic [31:0] iss_opb,
	input  wire logic [31:0] iss_acc,
	input  wire logic [31:0] iss_ea,
	input  wire logic [2:0]  iss_bytes,
	input  wire logic [6:0]  iss_str_len,
	input  wire logic        iss_cachable,
	input  wire logic [4:0]  iss_tgt,
	input  wire logic [4:0]  iss_src_a,
	input  wire logic        iss_src_a_en,
	input  wire logic [4:0]  iss_src_b,
	input  wire logic        iss_src_b_en,
	// Multiplier result and flags
	output logic             mul_res_valid,
	output logic [31:0]      mul_res,
	output logic             summary_overflow,
	output logic             overflow_flag,
	output logic [3:0]       condition_field_zero,
	// Data cache unit
	output logic             dcache_req_valid,
	output logic             dcache_req_write,
	output logic [31:0]      dcache_req_addr,
	output logic [2:0]       dcache_req_bytes,
	input  wire logic        dcache_hit,
	input  wire logic        dcache_fill_valid,
	input  wire logic        dcache_store_done,
	output logic [1:0]       store_queue_count,
	output logic             load_miss_pending,
	output logic             align_error,
	// Instruction fetch
	input  wire logic        icache_miss,
	input  cet_ifkind_t      icache_miss_kind,
	input  wire logic        fetch_queue_simple,
	output logic             fetch_hold
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	cet_state_t                    st_q, st_d;
	logic [2:0]                    busy_q, busy_d;
	logic [31:0]                   walk_addr_q;
	logic [6:0]                    walk_rem_q;
	logic                          walk_wr_q, walk_str_q, walk_cach_q;
	logic [4:0]                    ld_tgt_q;
	logic                          ld_recent_q, ld_pend_q;
	logic [1:0]                    sq_cnt_q;
	logic                          align_err_q;
	logic [2:0]                    if_cnt_q;
	logic                          if_seq_q;
	logic [31:0]                   mac_acc_q;
	logic [MUL_SLOTS-1:0]          svld_q, svld_d;
	logic [MUL_SLOTS-1:0][34:0]    sdat_q, sdat_d;
	logic                          res_vld_q, so_q, ov_q;
	logic [31:0]                   res_q;
	logic [3:0]                    crz_q;

	// ------------------------------------------------------------
	// Issue decode
	// ------------------------------------------------------------
	wire is_mac   = (iss_op == OP_MAC) || (iss_op == OP_NMAC);
	wire is_mul   = is_mac || (iss_op == OP_MUL);
	wire is_ld    = (iss_op == OP_LOAD) || (iss_op == OP_LWARX);
	wire is_st    = (iss_op == OP_STORE) || (iss_op == OP_STWCX);
	wire is_str   = (iss_op == OP_LMW) || (iss_op == OP_STMW);
	wire is_wr    = is_st || (iss_op == OP_STMW);
	wire is_mem   = is_ld || is_st || is_str;
	wire is_resv  = (iss_op == OP_LWARX) || (iss_op == OP_STWCX);

	wire [1:0] size_mask = iss_bytes[1:0] - 2'h1;
	wire       unal      = |(iss_ea[1:0] & size_mask);
	wire       resv_bad  = is_resv && (iss_ea[1:0] != WORD_ALIGN_LO);

	wire uses_ld    = (iss_src_a_en && (iss_src_a == ld_tgt_q)) || (iss_src_b_en && (iss_src_b == ld_tgt_q));
	wire use_stall  = uses_ld && (ld_recent_q || ld_pend_q);
	wire pend_stall = ld_pend_q && (is_ld || (iss_op == OP_LMW));
	wire sq_full    = (sq_cnt_q == STORE_Q_DEPTH);
	wire sq_stall   = is_wr && sq_full;
	wire in_idle    = (st_q == ST_IDLE);

	// Independent instructions other than loads and LMW are not held by an outstanding single-load miss; a string miss holds all issue in ST_WAIT.
	assign iss_ready = in_idle && (busy_q == 3'h0) && !use_stall && !pend_stall && !sq_stall;

	wire fire     = iss_valid && iss_ready;
	wire mem_fire = fire && is_mem && !resv_bad;
	wire mul_fire = fire && is_mul;

	// ------------------------------------------------------------
	// Access walking
	// ------------------------------------------------------------
	wire [6:0] first_rem = is_str ? iss_str_len : {4'h0, iss_bytes};
	wire [1:0] sp_lo     = in_idle ? iss_ea[1:0] : walk_addr_q[1:0];
	wire [6:0] sp_rem    = in_idle ? first_rem : walk_rem_q;
	wire [2:0] sp_chunk;
	wire       sp_cross;

	cet_access_splitter u_split (
		.addr_lo (sp_lo),
		.remain  (sp_rem),
		.chunk   (sp_chunk),
		.crosses (sp_cross)
	);

	wire cur_wr    = in_idle ? is_wr : walk_wr_q;
	wire cur_cach  = in_idle ? iss_cachable : walk_cach_q;
	wire str_now   = in_idle ? is_str : walk_str_q;
	wire walking   = (st_q == ST_BUSY) || (st_q == ST_SPLIT);
	wire walk_hold = walk_wr_q && sq_full;
	wire req_idle  = mem_fire && (first_rem != 7'h00);
	wire req_walk  = walking && (walk_rem_q != 7'h00) && !walk_hold;

	assign dcache_req_valid = req_idle || req_walk;
	assign dcache_req_write = cur_wr;
	assign dcache_req_addr  = in_idle ? iss_ea : walk_addr_q;
	assign dcache_req_bytes = sp_chunk;

	wire [6:0]  rem_after   = sp_rem - {4'h0, sp_chunk};
	wire [31:0] addr_after  = dcache_req_addr + {29'h0, sp_chunk};
	wire        req_miss_ld = dcache_req_valid && !cur_wr && !dcache_hit;
	wire        ld_hit_req  = dcache_req_valid && !cur_wr && !str_now && dcache_hit;
	wire        sq_inc      = dcache_req_valid && cur_wr && (!dcache_hit || !cur_cach);
	wire        sq_dec      = dcache_store_done && (sq_cnt_q != 2'h0);

	// Each cycle in the walk moves one piece, so leading, aligned and trailing parts cost a cycle each.
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: begin
				if (mem_fire && is_str) begin
					if (req_miss_ld) begin
						st_d = ST_WAIT;
					end else if (rem_after != 7'h00) begin
						st_d = ST_BUSY;
					end
				end else if (mem_fire && unal) begin
					st_d = ST_SPLIT;
				end
			end
			ST_BUSY: begin
				if (req_walk && req_miss_ld) begin
					st_d = ST_WAIT;
				end else if (req_walk && (rem_after == 7'h00)) begin
					st_d = ST_IDLE;
				end
			end
			ST_WAIT: begin
				if (dcache_fill_valid) begin
					st_d = (walk_rem_q != 7'h00) ? ST_BUSY : ST_IDLE;
				end
			end
			ST_SPLIT: begin
				if (req_walk || (walk_rem_q == 7'h00)) begin
					st_d = ST_IDLE;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Multiplier
	// ------------------------------------------------------------
	wire [2:0] mul_reissue;
	wire [2:0] mul_latency;

	cet_mul_sizer u_sizer (
		.is_mac      (is_mac),
		.form        (iss_mform),
		.is_unsigned (iss_unsigned),
		.opa         (iss_opa),
		.opb         (iss_opb),
		.reissue     (mul_reissue),
		.latency     (mul_latency)
	);

	// The issue slot is held for the reissue figure only when the next multiply can overlap.
	wire [2:0] mul_cycles = (iss_next_mul && !iss_next_dep) ? mul_reissue : mul_latency;

	wire [63:0] prod_s   = $signed({{32{iss_opa[31]}}, iss_opa}) * $signed({{32{iss_opb[31]}}, iss_opb});
	wire [63:0] prod_u   = {32'h0, iss_opa} * {32'h0, iss_opb};
	wire [63:0] prod     = iss_unsigned ? prod_u : prod_s;
	wire [31:0] acc_src  = iss_acc_fwd ? mac_acc_q : iss_acc;
	wire [31:0] mac_val  = (iss_op == OP_NMAC) ? (acc_src - prod[31:0]) : (acc_src + prod[31:0]);
	wire [31:0] mul_val  = is_mac ? mac_val : (iss_high ? prod[63:32] : prod[31:0]);
	wire        ovf      = !is_mac && (prod[63:31] != {33{prod[31]}});
	wire [34:0] mul_word = {iss_rc, iss_oe, ovf, mul_val};

	// Results enter the slot matching their latency and shift toward the output.
	for (genvar i = 0; i < MUL_SLOTS; i++) begin : g_slot
		wire ins = mul_fire && (mul_latency == 3'(i + 2));
		if (i < MUL_SLOTS - 1) begin : g_mid
			assign svld_d[i] = ins || svld_q[i+1];
			assign sdat_d[i] = ins ? mul_word : sdat_q[i+1];
		end else begin : g_top
			assign svld_d[i] = ins;
			assign sdat_d[i] = mul_word;
		end
	end

	wire [34:0] out_w  = sdat_q[0];
	wire        out_ov = out_w[SL_OE] && out_w[SL_OV];
	wire        so_new = so_q || out_ov;
	wire [3:0]  crz_new = {out_w[31], !out_w[31] && (out_w[31:0] != 32'h0), out_w[31:0] == 32'h0, so_new};

	always_comb begin
		busy_d = (busy_q != 3'h0) ? (busy_q - 3'h1) : 3'h0;
		if (mul_fire) begin
			busy_d = mul_cycles - 3'h1;
		end else if (fire && (iss_op == OP_STWCX) && !resv_bad) begin
			busy_d = STWCX_CYCLES - 3'h1;
		end
	end

	// ------------------------------------------------------------
	// Fetch miss penalty
	// ------------------------------------------------------------
	// The figures hold only for a bus at core rate that answers address and data back to back.
	wire [2:0] if_pen = (icache_miss_kind == IF_BR_DECODE)   ? IMISS_DECODE :
	                    (icache_miss_kind == IF_BR_PREFETCH) ? IMISS_PREFETCH : IMISS_SEQ;
	// After a sequential miss, a stalled head of a non-simple queue means the queue is not covering the miss, so the count pauses.
	wire       if_pause = if_seq_q && !fetch_queue_simple && iss_valid && !iss_ready;
	wire [2:0] if_cnt_d = icache_miss ? if_pen :
	                      ((if_cnt_q != 3'h0) && !if_pause) ? (if_cnt_q - 3'h1) : if_cnt_q;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q   <= ST_IDLE;
			busy_q <= 3'h0;
		end else begin
			st_q   <= st_d;
			busy_q <= busy_d;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			walk_addr_q <= 32'h0;
			walk_rem_q  <= 7'h00;
		end else if (dcache_req_valid) begin
			walk_addr_q <= addr_after;
			walk_rem_q  <= rem_after;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			walk_wr_q   <= 1'b0;
			walk_str_q  <= 1'b0;
			walk_cach_q <= 1'b0;
			ld_tgt_q    <= 5'h00;
		end else if (mem_fire) begin
			walk_wr_q   <= is_wr;
			walk_str_q  <= is_str;
			walk_cach_q <= iss_cachable;
			ld_tgt_q    <= iss_tgt;
		end
	end

	// A new miss in the cycle of a fill keeps the pending flag set.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ld_recent_q <= 1'b0;
			ld_pend_q   <= 1'b0;
			sq_cnt_q    <= 2'h0;
			align_err_q <= 1'b0;
		end else begin
			ld_recent_q <= ld_hit_req || (ld_pend_q && dcache_fill_valid);
			ld_pend_q   <= (req_miss_ld && !str_now) || (ld_pend_q && !dcache_fill_valid);
			sq_cnt_q    <= sq_cnt_q + {1'b0, sq_inc} - {1'b0, sq_dec};
			align_err_q <= fire && resv_bad;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			if_cnt_q <= 3'h0;
			if_seq_q <= 1'b0;
		end else begin
			if_cnt_q <= if_cnt_d;
			if_seq_q <= icache_miss ? (icache_miss_kind == IF_SEQ) : if_seq_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			svld_q    <= '0;
			sdat_q    <= '0;
			mac_acc_q <= 32'h0;
		end else begin
			svld_q    <= svld_d;
			sdat_q    <= sdat_d;
			mac_acc_q <= (mul_fire && is_mac) ? mac_val : mac_acc_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			res_vld_q <= 1'b0;
			res_q     <= 32'h0;
			so_q      <= 1'b0;
			ov_q      <= 1'b0;
			crz_q     <= 4'h0;
		end else begin
			res_vld_q <= svld_q[0];
			res_q     <= svld_q[0] ? out_w[31:0] : res_q;
			so_q      <= (svld_q[0] && out_w[SL_OE]) ? so_new : so_q;
			ov_q      <= (svld_q[0] && out_w[SL_OE]) ? out_w[SL_OV] : ov_q;
			crz_q     <= (svld_q[0] && out_w[SL_RC]) ? crz_new : crz_q;
		end
	end

	assign mul_res_valid        = res_vld_q;
	assign mul_res              = res_q;
	assign summary_overflow     = so_q;
	assign overflow_flag        = ov_q;
	assign condition_field_zero = crz_q;
	assign store_queue_count    = sq_cnt_q;
	assign load_miss_pending    = ld_pend_q;
	assign align_error          = align_err_q;
	assign fetch_hold           = (if_cnt_q != 3'h0);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	wire ld_hit_fire = fire && (iss_op == OP_LOAD) && !unal && dcache_hit;

	AST_MAC_LATENCY: assert property (mul_fire && is_mac |-> ##2 mul_res_valid)
		else $error("accumulate result not delivered after two cycles");
	AST_MAC_REISSUE: assert property (mul_fire && is_mac && iss_next_mul && !iss_next_dep |=> busy_q == 3'h0)
		else $error("accumulate run slowed below one per cycle");
	AST_HH_LATENCY: assert property (mul_fire && (iss_op == OP_MUL) && (iss_mform == MF_HH) |-> ##2 mul_res_valid)
		else $error("halfword multiply latency wrong");
	AST_WW_REISSUE: assert property (mul_fire && (mul_reissue == WW_REISSUE) && iss_next_mul && !iss_next_dep
			|=> (busy_q != 3'h0) [*3] ##1 (busy_q == 3'h0))
		else $error("word multiply reissue is not four cycles");
	AST_WW_LATENCY: assert property (mul_fire && (mul_latency == WW_LATENCY) |-> ##5 mul_res_valid)
		else $error("word multiply latency is not five cycles");
	AST_PLAIN_FLAGS: assert property (svld_q[0] && !out_w[SL_OE] |=> $stable(overflow_flag))
		else $error("plain multiply changed the overflow flag");
	AST_LOAD_HIT: assert property (ld_hit_fire |=> (st_q == ST_IDLE) && !ld_pend_q)
		else $error("hitting load did not finish in one cycle");
	AST_LOAD_USE: assert property (ld_hit_fire ##1 (iss_valid && uses_ld) |-> !iss_ready)
		else $error("load consumer issued without the forwarding cycle");
	AST_MISS_OVERLAP: assert property (ld_pend_q && iss_valid && (iss_op == OP_ALU) && !uses_ld && in_idle
			&& (busy_q == 3'h0) |-> iss_ready)
		else $error("independent instruction held by a load miss");
	AST_SQ_LIMIT: assert property (sq_full && iss_valid && is_wr |-> !iss_ready)
		else $error("store taken with the queue full");
	AST_STWCX: assert property (fire && (iss_op == OP_STWCX) && !resv_bad |=> !iss_ready ##1 (busy_q == 3'h0))
		else $error("conditional store did not take two cycles");
	AST_UNALIGNED: assert property (mem_fire && !is_str && unal |=> st_q == ST_SPLIT)
		else $error("unaligned access missed its extra cycle");
	AST_NO_CROSS: assert property (dcache_req_valid |-> ({1'b0, dcache_req_addr[1:0]} + dcache_req_bytes) <= WORD_BYTES)
		else $error("request crosses a word boundary");
	AST_IMISS: assert property (icache_miss && (icache_miss_kind == IF_BR_DECODE) |=> fetch_hold [*5])
		else $error("taken branch miss from decode held fetch too briefly");

	COV_MAC_RUN: cover property (mul_fire && is_mac ##1 mul_fire && is_mac && iss_acc_fwd);
	COV_MISS_HIDE: cover property (req_miss_ld ##1 (fire && ld_pend_q) ##1 (fire && ld_pend_q));
	COV_STRING: cover property (mem_fire && is_str ##1 (st_q == ST_BUSY) [*3] ##1 (st_q == ST_IDLE));
	COV_SPLIT: cover property (req_idle && sp_cross ##1 req_walk);

endmodule // cet_timing_ctrl

//--- verification/cet_dcu_model.sv
// Cache unit model: same-cycle answers, stores always queued and retired slowly.
`timescale 1ns/1ps
module cet_dcu_model (
	// Clock, reset and stall control
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic hold_st,
	// Request and answers
	input  wire logic req_valid,
	input  wire logic req_write,
	output logic      hit,
	output logic      fill_valid,
	output logic      store_done
);
	logic [2:0] pend_q;
	logic       tog_q;
	// Every store misses so that the queue in front of this model really fills.
	assign hit        = !req_write;
	assign fill_valid = 1'b0;
	assign store_done = (pend_q != 3'h0) && !hold_st && tog_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_q <= 3'h0;
			tog_q  <= 1'b0;
		end else begin
			pend_q <= pend_q + {2'h0, req_valid && req_write} - {2'h0, store_done};
			tog_q  <= !tog_q;
		end
	end
endmodule // cet_dcu_model

//--- verification/cet_timing_ctrl_tb_top.sv
// Self-checking bench of the execution timing controller.
`timescale 1ns/1ps
module cet_timing_ctrl_tb_top;
	import cet_pkg::*;
	logic        core_clk = 1'b0, rst_b = 1'b0, iss_valid = 1'b0, iss_unsigned = 1'b0, iss_high = 1'b0, iss_oe, iss_rc;
	logic        iss_acc_fwd = 1'b0, iss_next_mul, iss_next_dep, iss_cachable, iss_src_a_en, iss_src_b_en, hold_st = 1'b0;
	logic        icache_miss = 1'b0, fetch_queue_simple = 1'b1, iss_ready, mul_res_valid, summary_overflow, overflow_flag;
	logic        dcache_hit, dcache_req_valid, dcache_req_write, dcache_fill_valid, dcache_store_done, so_m = 1'b0;
	logic        load_miss_pending, align_error, fetch_hold;
	cet_op_t     iss_op = OP_ALU;
	cet_mform_t  iss_mform = MF_HH;
	cet_ifkind_t icache_miss_kind = IF_SEQ;
	logic [31:0] iss_opa, iss_opb, iss_acc, iss_ea, mul_res, dcache_req_addr;
	logic [2:0]  iss_bytes, dcache_req_bytes;
	logic [6:0]  iss_str_len;
	logic [4:0]  iss_tgt = 5'h1F, iss_src_a, iss_src_b;
	logic [3:0]  condition_field_zero;
	logic [1:0]  store_queue_count;
	logic [35:0] q0;
	integer      seed = 32'h2108, error_cnt = 0, comparisons = 0, cyc = 0, tk, i, j, n1;
	int          tr [8][8] = '{'{2,0,0,0,1,0,1,2}, '{3,0,0,0,1,0,1,2}, '{1,0,0,0,1,0,1,2}, '{1,1,0,1,1,0,2,3},
		'{1,2,1,1,1,0,4,5}, '{1,2,0,1,1,0,2,3}, '{1,2,1,1,0,0,5,5}, '{1,2,1,1,1,1,5,5}};
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) cyc <= cyc + 1;
	cet_timing_ctrl dut_u (.*);
	cet_dcu_model dcu_u (.core_clk(core_clk), .rst_b(rst_b), .hold_st(hold_st), .req_valid(dcache_req_valid),
		.req_write(dcache_req_write), .hit(dcache_hit), .fill_valid(dcache_fill_valid), .store_done(dcache_store_done));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Halfword operands arrive sign-extended; wide ones never look narrow to the sizer.
	function automatic logic [31:0] opnd(input int w);
		logic [31:0] r;
		r = $random(seed);
		return w ? {2'b01, r[29:0]} : {{16{r[15]}}, r[15:0]};
	endfunction
	task automatic issue(input cet_op_t o, input cet_mform_t f, input logic [31:0] x, y, e, input int n, m, d);
		@(negedge core_clk);
		iss_op = o;
		iss_mform = f;
		{iss_opa, iss_opb, iss_ea, iss_bytes} = {x, y, e, n[2:0]};
		{iss_next_mul, iss_next_dep, iss_cachable, iss_valid} = {m[0], d[0], o == OP_LOAD, 1'b1};
		iss_acc = $random(seed);
		{iss_oe, iss_src_a, iss_src_b, iss_src_a_en, iss_src_b_en, iss_rc, iss_str_len} = 21'($random(seed)) & 21'h17BFFF;
		#1;
		for (int k = 0; k < 30 && !iss_ready; k++) @(negedge core_clk);
		tk = cyc;
		q0 = {dcache_req_valid, dcache_req_bytes, dcache_req_addr};
		@(posedge core_clk);
	endtask
	task automatic mulrun(input int w [8]);
		logic [31:0] x, y, e;
		longint      p;
		logic        ov;
		int          rr = 0, lr = 0;
		x = opnd(w[2]);
		y = opnd(w[3]);
		issue(cet_op_t'(w[0]), cet_mform_t'(w[1]), x, y, 32'h0, 4, w[4], w[5]);
		p = longint'($signed(x)) * longint'($signed(y));
		e = (w[0] == 1) ? p[31:0] : (w[0] == 2) ? iss_acc + x * y : iss_acc - x * y;
		ov = (w[0] == 1) && (p != longint'($signed(p[31:0])));
		for (int k = 0; k < 8; k++) begin
			@(negedge core_clk);
			iss_valid = 1'b0;
			#1;
			if (iss_ready && rr == 0) rr = cyc - tk;
			if (mul_res_valid && lr == 0) begin
				lr = cyc - tk;
				chk(mul_res, e);
				so_m = so_m | (ov & iss_oe);
				if (iss_oe) chk({summary_overflow, overflow_flag}, {so_m, ov});
				if (iss_rc) chk(condition_field_zero, {e[31], !e[31] && (e != 0), e == 0, so_m});
			end
		end
		chk(rr, w[6]);
		chk(lr, w[7]);
	endtask
	initial begin
		repeat (16) @(negedge core_clk);
		rst_b = 1'b1;
		hold_st = 1'b1;
		for (i = 0; i < 3; i++) begin
			issue(OP_STORE, MF_HH, 0, 0, 32'h2000_0000 + 4 * i, 4, 0, 0);
			j = (i == 0) ? tk : j;
		end
		@(negedge core_clk);
		#1;
		chk(tk - j, 2);
		chk({store_queue_count, iss_ready}, {2'h3, 1'b0});
		{iss_valid, hold_st} = 2'b00;
		repeat (12) @(negedge core_clk);
		chk(store_queue_count, 0);
		$display("test store queue done");
		for (i = 0; i < 8; i++) begin
			j = (i < 4) ? 4 : 2;
			n1 = (j < 4 - i % 4) ? j : 4 - i % 4;
			issue(OP_LOAD, MF_HH, 0, 0, 32'h1000_0040 + i % 4, j, 0, 0);
			chk(q0, {1'b1, n1[2:0], 32'h1000_0040 + i % 4});
			@(negedge core_clk);
			iss_valid = 1'b0;
			#1;
			chk(dcache_req_valid, i % 4 + j > 4);
			if (i % 4 + j > 4) chk({dcache_req_bytes, dcache_req_addr}, {j[2:0] - n1[2:0], 32'h1000_0044});
			chk(iss_ready, ((i % 4) & (j - 1)) == 0);
			chk(load_miss_pending, 0);
		end
		for (i = 0; i < 2; i++) begin
			issue(OP_STWCX, MF_HH, 0, 0, 32'h1000_0040 + 2 * i, 4, 0, 0);
			@(negedge core_clk);
			iss_valid = 1'b0;
			#1;
			chk(align_error, i);
			if (i == 0) chk(iss_ready, 0);
		end
		$display("test access split done");
		for (i = 0; i < 8; i++) mulrun(tr[i]);
		$display("test multiply done");
		for (i = 0; i < 3; i++) begin
			@(negedge core_clk);
			{icache_miss, icache_miss_kind} = {1'b1, cet_ifkind_t'(i)};
			@(negedge core_clk);
			icache_miss = 1'b0;
			n1 = 0;
			for (j = 0; j < 8; j++) begin
				#1;
				n1 += fetch_hold;
				@(negedge core_clk);
			end
			chk(n1, (i == 0) ? 3 : (i == 1) ? 5 : 4);
		end
		$display("test fetch miss done");
		tally_and_finish();
	end
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end
endmodule // cet_timing_ctrl_tb_top
